//--- bobo_regs.svh
// Functional notes
// - Tested bit one loads PC with next-instruction address plus displacement.
// - Tested bit zero advances PC by one and continues in sequence.
// - Displacement is added to the address following the branch instruction.
// - Address register post-update always happens, branch taken or not.
// - Displacement is a 32-bit two's complement extension word.
// - Reading system stack high as source decrements the stack pointer.
// - A 5-bit immediate field selects bit 0 to 31 under test.
// - Memory alterable, absolute short, I/O short and register sources are supported.
// - Effective address uses R0-R7 indirect modes, no register-plus-displacement mode.
// - Absolute short carries 7-bit address; space bit picks X or Y.
// - I/O short carries 7-bit peripheral address with the same space bit.
// - Two program words and eight oscillator cycles; up to five operand wait cycles fit inside the eight.
// - Condition code, exception status and exception flag bits stay unchanged.
`ifndef BOBO_REGS_SVH
`define BOBO_REGS_SVH
`define BOBO_TOP_HI 31
`define BOBO_TOP_LO 20
`define BOBO_TOP_VAL 12'h02a
`define BOBO_TOP_EA 12'h028
`define BOBO_TOP_REG 12'h02b
`define BOBO_SHORT_BIT 19
`define BOBO_LOW_HI 11
`define BOBO_LOW_LO 9
`define BOBO_LOW_VAL 3'h6
`define BOBO_LOWZ_HI 7
`define BOBO_LOWZ_LO 5
`define BOBO_SPACE_BIT 8
`define BOBO_BIT_HI 4
`define BOBO_ADDR_HI 18
`define BOBO_ADDR_LO 12
`define BOBO_REG_HI 19
`define BOBO_REG_LO 13
`define BOBO_REG0_BIT 12
`define BOBO_MODE_HI 19
`define BOBO_MODE_LO 17
`define BOBO_RN_HI 16
`define BOBO_RN_LO 14
`define BOBO_MODE_DISP 3'h7
`define BOBO_REG_SSH 7'h7c
`define BOBO_CYCLES 4'h8
`define BOBO_ONE 32'h00000001
`define BOBO_RC_GRP_HI 6
`define BOBO_RC_GRP_LO 3
`define BOBO_RC_NUM_HI 2
`define BOBO_RC_DMAIN_HI 6
`define BOBO_RC_DMAIN_LO 5
`define BOBO_RC_DMAIN 2'h0
`define BOBO_RC_DEXT 4'h4
`define BOBO_RC_ADDR 4'h5
`define BOBO_RC_OFS 4'h6
`define BOBO_RC_MOD 4'h7
`define BOBO_RC_CTL 4'hf
`define BOBO_RC_NONE 3'h0
`define BOBO_CNT_RST 4'h0
`define BOBO_CNT_START 4'h1
`define BOBO_CNT_STEP 4'h1
`define BOBO_PC_RST 32'h00000000
`endif

//--- bobo_pkg.sv
package bobo_pkg;
    typedef enum logic [1:0] {BOBO_SRC_EA, BOBO_SRC_ABS, BOBO_SRC_IO, BOBO_SRC_REG} bobo_src_t;
    typedef struct packed {
        logic valid;
        bobo_src_t src;
        logic y_space;
        logic [6:0] short_addr;
        logic [6:0] reg_code;
        logic [2:0] ea_mode;
        logic [2:0] ea_reg;
        logic [4:0] bit_sel;
    } bobo_dec_t;
    typedef struct packed {
        logic rd;
        logic y_space;
        logic io;
        logic [6:0] short_addr;
    } bobo_mem_t;
endpackage

//--- bobo_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "bobo_regs.svh"
module bobo_exec
    import bobo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [31:0] opcode,
    input wire logic [31:0] ext_word,
    input wire logic [31:0] pc_in,
    input wire logic [31:0] operand,
    input wire logic operand_valid,
    output logic busy,
    output logic done,
    output logic illegal,
    output logic taken,
    output bobo_dec_t dec_out,
    output bobo_mem_t mem_req,
    output logic ea_update,
    output logic [2:0] ea_reg_sel,
    output logic [2:0] ea_mode_sel,
    output logic [6:0] reg_read_code,
    output logic reg_read,
    output logic stack_pop,
    output logic pc_load,
    output logic [31:0] pc_out
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_DONE} bobo_state_t;
    bobo_state_t state_reg, state_next;
    bobo_dec_t dec_reg;
    logic [3:0] cnt_reg;
    logic [31:0] pc_reg;
    logic taken_reg;
    wire [11:0] top = opcode[`BOBO_TOP_HI:`BOBO_TOP_LO];
    // ----------------------------------------
    // Register source codes
    // ----------------------------------------
    // Unassigned codes are refused so a stray opcode never reads a random register.
    wire [6:0] rcode = opcode[`BOBO_REG_HI:`BOBO_REG_LO];
    wire [3:0] rc_grp = rcode[`BOBO_RC_GRP_HI:`BOBO_RC_GRP_LO];
    wire [2:0] rc_num = rcode[`BOBO_RC_NUM_HI:0];
    wire rc_data_main = rcode[`BOBO_RC_DMAIN_HI:`BOBO_RC_DMAIN_LO] == `BOBO_RC_DMAIN;
    wire rc_data_ext = rc_grp == `BOBO_RC_DEXT;
    wire rc_addr = rc_grp == `BOBO_RC_ADDR;
    wire rc_offset = rc_grp == `BOBO_RC_OFS;
    wire rc_modifier = rc_grp == `BOBO_RC_MOD;
    wire rc_control = rc_grp == `BOBO_RC_CTL && rc_num != `BOBO_RC_NONE;
    wire rc_ok = rc_data_main || rc_data_ext || rc_addr || rc_offset || rc_modifier
        || rc_control;
    wire low_ok = opcode[`BOBO_LOW_HI:`BOBO_LOW_LO] == `BOBO_LOW_VAL
        && opcode[`BOBO_LOWZ_HI:`BOBO_LOWZ_LO] == 3'h0;
    wire is_reg = top == `BOBO_TOP_REG && !opcode[`BOBO_REG0_BIT] && rc_ok;
    wire is_short = top == `BOBO_TOP_VAL;
    wire is_ea = top == `BOBO_TOP_EA
        && opcode[`BOBO_MODE_HI:`BOBO_MODE_LO] != `BOBO_MODE_DISP;
    wire form_ok = is_reg || is_short || is_ea;
    wire dec_ok = low_ok && form_ok;
    bobo_dec_t dec_w;
    assign dec_w.valid = dec_ok;
    assign dec_w.src = is_reg ? BOBO_SRC_REG : is_ea ? BOBO_SRC_EA :
        opcode[`BOBO_SHORT_BIT] ? BOBO_SRC_IO : BOBO_SRC_ABS;
    // Register form forces X space, since its space bit position is a fixed zero.
    assign dec_w.y_space = opcode[`BOBO_SPACE_BIT] && !is_reg;
    assign dec_w.short_addr = opcode[`BOBO_ADDR_HI:`BOBO_ADDR_LO];
    assign dec_w.reg_code = opcode[`BOBO_REG_HI:`BOBO_REG_LO];
    assign dec_w.ea_mode = opcode[`BOBO_MODE_HI:`BOBO_MODE_LO];
    assign dec_w.ea_reg = opcode[`BOBO_RN_HI:`BOBO_RN_LO];
    assign dec_w.bit_sel = opcode[`BOBO_BIT_HI:0];
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // eight cycles, up to five operand wait cycles included
    wire cnt_end = cnt_reg == `BOBO_CYCLES - `BOBO_CNT_STEP;
    wire [3:0] cnt_next = (state_reg == ST_IDLE) ? `BOBO_CNT_START : cnt_reg + `BOBO_CNT_STEP;
    wire in_fetch = state_reg == ST_FETCH;
    wire fetch_go = in_fetch && operand_valid;
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (start && dec_ok)
                begin
                    state_next = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                // A source that never answers holds the block here; the core must answer.
                if (operand_valid)
                begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                // Operand waits in fetch use up the same count, so up to five of them add nothing to the total.
                if (cnt_end)
                begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end
    // ----------------------------------------
    // Operand test
    // ----------------------------------------
    // bit test
    wire bit_one = operand[dec_reg.bit_sel];
    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    // The adder is 32 bits wide, so a target wraps round the address space.
    // target from next address
    wire [31:0] pc_after = pc_in + `BOBO_ONE;
    wire [31:0] pc_tgt = pc_after + ext_word;
    wire [31:0] pc_next = bit_one ? pc_tgt : pc_after;
    // ----------------------------------------
    // State and cycle count
    // ----------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= `BOBO_CNT_RST;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end
    // ----------------------------------------
    // Decode capture
    // ----------------------------------------
    // Every start in idle is captured; an illegal one never leaves idle.
    wire dec_load = state_reg == ST_IDLE && start;
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            dec_reg <= '0;
        end
        else if (dec_load)
        begin
            dec_reg <= dec_w;
        end
    end
    // ----------------------------------------
    // Branch result
    // ----------------------------------------
    // The result holds until the next operand is accepted.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            pc_reg <= `BOBO_PC_RST;
            taken_reg <= 1'b0;
        end
        else if (fetch_go)
        begin
            taken_reg <= bit_one;
            pc_reg <= pc_next;
        end
    end
    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Condition codes and exception bits have no path out of this block.
    // flags untouched
    // Illegal is combinational so the core sees a refused start in the same cycle; busy comes from the state register.
    assign busy = state_reg != ST_IDLE;
    assign done = state_reg == ST_DONE;
    assign illegal = start && state_reg == ST_IDLE && !dec_ok;
    assign taken = taken_reg;
    assign dec_out = dec_reg;
    assign pc_out = pc_reg;
    assign pc_load = done;
    // ----------------------------------------
    // Source requests
    // ----------------------------------------
    assign mem_req.rd = in_fetch && dec_reg.src != BOBO_SRC_REG;
    assign mem_req.y_space = dec_reg.y_space;
    assign mem_req.io = dec_reg.src == BOBO_SRC_IO;
    assign mem_req.short_addr = dec_reg.short_addr;
    assign reg_read = in_fetch && dec_reg.src == BOBO_SRC_REG;
    assign reg_read_code = dec_reg.reg_code;
    // ----------------------------------------
    // Address update and stack
    // ----------------------------------------
    // always update
    assign ea_update = fetch_go && dec_reg.src == BOBO_SRC_EA;
    assign ea_reg_sel = dec_reg.ea_reg;
    assign ea_mode_sel = dec_reg.ea_mode;
    // Only the register form can pop; memory forms never touch the stack.
    // stack pop
    assign stack_pop = fetch_go && dec_reg.src == BOBO_SRC_REG
        && dec_reg.reg_code == `BOBO_REG_SSH;
endmodule
`default_nettype wire

//--- bobo_exec_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module bobo_exec_chk import bobo_pkg::*; (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [31:0] ext_word,
    input wire logic [31:0] pc_in,
    input wire logic busy,
    input wire logic done,
    input wire logic taken,
    input wire bobo_dec_t dec_out,
    input wire logic stack_pop,
    input wire logic [31:0] pc_out);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_seq; done && !taken |-> pc_out == pc_in + 32'h1; endproperty
    a_seq: assert property (p_seq) else $error("pc step");
    property p_jmp; done && taken |-> pc_out == pc_in + 32'h1 + ext_word; endproperty
    a_jmp: assert property (p_jmp) else $error("pc jump");
    property p_pls; done |=> !done; endproperty
    a_pls: assert property (p_pls) else $error("done width");
    property p_pop; stack_pop |-> dec_out.reg_code == 7'h7c; endproperty
    a_pop: assert property (p_pop) else $error("pop code");
    property p_bsy; done |-> busy; endproperty
    a_bsy: assert property (p_bsy) else $error("done idle");
    property p_idl; done |=> !busy; endproperty
    a_idl: assert property (p_idl) else $error("busy after");
    property p_hld; done |=> $stable(pc_out) && $stable(taken); endproperty
    a_hld: assert property (p_hld) else $error("pc hold");
    property p_pbs; stack_pop |-> busy && !done; endproperty
    a_pbs: assert property (p_pbs) else $error("pop time");
endmodule
bind bobo_exec bobo_exec_chk i_chk (.mclk, .rst_b, .ext_word, .pc_in, .busy, .done, .taken,
    .dec_out, .stack_pop, .pc_out);
`default_nettype wire

//--- bobo_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bobo_exec_tb;
    import bobo_pkg::*;
    logic mclk = 1'b0, rst_b = 1'b0, start = 1'b0, operand_valid = 1'b0, busy, done, illegal;
    logic taken, ea_update, stack_pop, reg_read, sp_seen, ea_seen, pc_load;
    logic [2:0] ea_reg_sel, ea_mode_sel;
    logic [6:0] reg_read_code;
    logic [31:0] opcode = '0, ext_word = '0, pc_in = '0, operand = '0, pc_out, cnt;
    bobo_mem_t mem_req, mq;
    int mismatches = 0, n_tests = 0;
    bobo_exec i_bobo_exec (.mclk, .rst_b, .start, .opcode, .ext_word, .pc_in, .operand,
        .operand_valid, .busy, .done, .illegal, .taken, .dec_out(), .mem_req, .ea_update,
        .ea_reg_sel, .ea_mode_sel, .reg_read_code, .reg_read, .stack_pop, .pc_load,
        .pc_out);
    always #25 mclk = ~mclk;
    task chk(input string nm, input logic [39:0] e, g);
        n_tests++;
        mismatches += (g !== e);
        if (g !== e)
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    endtask
    task tally_and_finish;
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Operands come at once; slow sources are not covered.
    task run(input logic [31:0] op, ext, opnd);
        @(negedge mclk) {opcode, ext_word, operand, pc_in, start} = {op, ext, opnd, 32'h1000, 1'b1};
        @(negedge mclk) {start, sp_seen, ea_seen, cnt} = 35'h1;
        while (done !== 1'b1 && cnt < 40)
        begin
            {operand_valid, mq} = {mem_req.rd | reg_read, mem_req.rd ? mem_req : mq};
            #1 {sp_seen, ea_seen} = {sp_seen | stack_pop, ea_seen | ea_update};
            @(negedge mclk) cnt++;
        end
        chk("result", {3'h7, opnd[op[4:0]], opnd[op[4:0]] ? 32'h1001 + ext : 32'h1001},
            {done, pc_load, cnt > 7 && cnt < 10, taken, pc_out});
        if (done !== 1'b1)
            tally_and_finish();
    endtask
    task t_register_forms;
        run({12'h02b, 7'h08, 5'h0c, 3'h0, 5'h1f}, 32'hffff_fff0, 32'h8000_0000);
        run({12'h02b, 7'h7c, 5'h0c, 3'h0, 5'h00}, 32'h40, 32'hffff_fffe);
        chk("stack_pop", 1, sp_seen);
        chk("reg code", 7'h7c, reg_read_code);
        @(negedge mclk) {opcode, start} = 33'h1;
        #1 chk("illegal", 1, illegal);
        @(negedge mclk) {opcode, start} = {12'h02b, 7'h48, 5'h0c, 3'h0, 5'h00, 1'b1};
        #1 chk("bad reg", 1, illegal);
        @(negedge mclk) {opcode, start} = {12'h028, 3'h7, 3'h0, 5'h06, 1'b0, 3'h0, 5'h00, 1'b1};
        #1 chk("disp mode", 1, illegal);
        @(negedge mclk) start = 1'b0;
        chk("busy", 0, busy);
    endtask
    task t_memory_forms;
        run({12'h028, 3'h3, 3'h5, 5'h06, 1'b1, 3'h0, 5'h05}, 32'h100, 32'h20);
        chk("ea y", 2'h3, {ea_seen, mq.y_space});
        chk("ea sel", {3'h3, 3'h5}, {ea_mode_sel, ea_reg_sel});
        run({12'h02a, 8'h55, 3'h6, 1'b0, 3'h0, 5'h11}, 32'h20, 32'h0);
        chk("abs", 9'h055, {mq.io, mq.y_space, mq.short_addr});
        run({12'h02a, 8'hd5, 3'h6, 1'b1, 3'h0, 5'h11}, 32'h20, 32'h0002_0000);
        chk("io", 9'h1d5, {mq.io, mq.y_space, mq.short_addr});
    endtask
    initial
    begin
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        t_register_forms();
        t_memory_forms();
        tally_and_finish();
    end
endmodule
`default_nettype wire
